// ==== design/icm_regs.vh ====
// constants of the crop and mirror stage: sensor size, register map, fields
// assumes a 32-bit register port addressed in bytes, one word per register
`ifndef ICM_REGS_VH
`define ICM_REGS_VH

// sensor size, 1034 columns by 779 rows
`define ICM_SENSOR_W 11'h40a
`define ICM_SENSOR_H 11'h30b

`define ICM_POS_W 11
`define ICM_PIX_W 12
`define ICM_ADDR_W 8
`define ICM_BUF_AW 12

// register offsets
`define ICM_OFS_COL_START 8'h00
`define ICM_OFS_ROW_START 8'h04
`define ICM_OFS_WIDTH 8'h08
`define ICM_OFS_HEIGHT 8'h0c
`define ICM_OFS_CTRL 8'h10
`define ICM_OFS_STATUS 8'h14

// reset values: full sensor window, no mirroring
`define ICM_RST_COL_START 11'h000
`define ICM_RST_ROW_START 11'h000
`define ICM_RST_WIDTH `ICM_SENSOR_W
`define ICM_RST_HEIGHT `ICM_SENSOR_H
`define ICM_RST_MIRROR 1'h0

// field positions
`define ICM_CTRL_MIRROR 0
`define ICM_STAT_BUSY 0
`define ICM_STAT_WIN_OK 1
`define ICM_STAT_FCNT_LSB 16
`define ICM_STAT_FCNT_MSB 31

`endif

// ==== design/icm_pos_track.v ====
// sensor position tracker: column and row of the pixel now on the input
// assumes a start-of-frame flag on the first pixel, end-of-line on the last
`timescale 1ns/1ps
`include "icm_regs.vh"

module icm_pos_track (
  input wire clk,
  input wire reset_n,
  input wire valid,
  input wire sof,
  input wire eol,
  output wire [`ICM_POS_W-1:0] col,
  output wire [`ICM_POS_W-1:0] row
);
  reg [`ICM_POS_W-1:0] col_cnt;
  reg [`ICM_POS_W-1:0] row_cnt;

  // first pixel of a frame is column 0, row 0 no matter what came before
  assign col = sof ? {`ICM_POS_W{1'b0}} : col_cnt;
  assign row = sof ? {`ICM_POS_W{1'b0}} : row_cnt;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      col_cnt <= {`ICM_POS_W{1'b0}};
      row_cnt <= {`ICM_POS_W{1'b0}};
    end else if (valid) begin
      if (eol) begin
        col_cnt <= {`ICM_POS_W{1'b0}};
        row_cnt <= row + 11'h001;
      end else begin
        col_cnt <= col + 11'h001;
        row_cnt <= row;
      end
    end
  end
endmodule

// ==== design/icm_line_buf.v ====
// ping-pong line store: two banks of one sensor line each
// assumes one write and one read port on the same clock; read data one
// cycle after the read address
`timescale 1ns/1ps
`include "icm_regs.vh"

module icm_line_buf (
  input wire clk,
  input wire reset_n,
  input wire wr_en,
  input wire [`ICM_BUF_AW-1:0] wr_addr,
  input wire [`ICM_PIX_W-1:0] wr_data,
  input wire rd_en,
  input wire [`ICM_BUF_AW-1:0] rd_addr,
  output reg [`ICM_PIX_W-1:0] rd_data
);
  // bank bit on top, column below; columns past 1033 stay unused
  reg [`ICM_PIX_W-1:0] mem [0:(1<<`ICM_BUF_AW)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= {`ICM_PIX_W{1'b0}};
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ==== design/icm_crop_mirror.v ====
// crop and mirror stage of the pixel stream, with its register port
// assumes pixel stream and register port both on CLK; a full input line
// always spans at least as many valid cycles as the cropped line it follows
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "icm_regs.vh"

module icm_crop_mirror (
  input wire CLK,
  input wire RESET_N,
  input wire [`ICM_ADDR_W-1:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [31:0] REG_RDATA,
  input wire PIX_VALID,
  input wire [`ICM_PIX_W-1:0] PIX_DATA,
  input wire PIX_SOF,
  input wire PIX_EOL,
  output reg OUT_VALID,
  output reg [`ICM_PIX_W-1:0] OUT_DATA,
  output reg OUT_SOF,
  output reg OUT_EOL,
  output reg OUT_EOF
);
  localparam ST_IDLE = 1'b0;
  localparam ST_READ = 1'b1;

  // software copies of the settings
  reg [`ICM_POS_W-1:0] column_start_sw;
  reg [`ICM_POS_W-1:0] row_start_sw;
  reg [`ICM_POS_W-1:0] width_sw;
  reg [`ICM_POS_W-1:0] height_sw;
  reg mirror_enable_sw;

  // settings in force for the frame now arriving
  reg [`ICM_POS_W-1:0] column_start;
  reg [`ICM_POS_W-1:0] row_start;
  reg [`ICM_POS_W-1:0] width;
  reg [`ICM_POS_W-1:0] height;
  reg mirror_enable;

  reg frame_busy;
  reg [15:0] frame_count;
  reg [31:0] next_rdata;

  // readout side
  reg state;
  reg wr_bank;
  reg rd_bank;
  reg [`ICM_POS_W-1:0] rd_len;
  reg [`ICM_POS_W-1:0] rd_idx;
  reg rd_mirror;
  reg rd_first;
  reg rd_last;
  reg s1_valid;
  reg s1_sof;
  reg s1_eol;
  reg s1_eof;

  wire [`ICM_POS_W-1:0] pix_col;
  wire [`ICM_POS_W-1:0] pix_row;
  wire [`ICM_PIX_W-1:0] buf_dout;

  // true when pos lies in [start, start+len); 12-bit sum avoids wrap
  function in_span;
    input [`ICM_POS_W-1:0] pos;
    input [`ICM_POS_W-1:0] start;
    input [`ICM_POS_W-1:0] len;
    begin
      in_span = (pos >= start) &&
        ({1'b0, pos} < ({1'b0, start} + {1'b0, len}));
    end
  endfunction

  // the first pixel of a frame already uses the new settings
  wire frame_start = PIX_VALID & PIX_SOF;
  wire [`ICM_POS_W-1:0] eff_cs = PIX_SOF ? column_start_sw : column_start;
  wire [`ICM_POS_W-1:0] eff_rs = PIX_SOF ? row_start_sw : row_start;
  wire [`ICM_POS_W-1:0] eff_w = PIX_SOF ? width_sw : width;
  wire [`ICM_POS_W-1:0] eff_h = PIX_SOF ? height_sw : height;
  wire eff_mirror = PIX_SOF ? mirror_enable_sw : mirror_enable;

  wire col_hit = in_span(pix_col, eff_cs, eff_w);
  wire row_hit = in_span(pix_row, eff_rs, eff_h);
  wire keep = PIX_VALID & col_hit & row_hit;
  wire line_done = PIX_VALID & PIX_EOL & row_hit & (eff_w != 11'h000);

  // last kept row index; sum fits 12 bits, result cut back to position width
  wire [`ICM_POS_W:0] last_row_sum = {1'b0, eff_rs} + {1'b0, eff_h} - 12'h001;
  wire is_last_row = (pix_row == last_row_sum[`ICM_POS_W-1:0]);

  // window placed in sensor terms; written at offset from its own start, reversed within its width on readout when mirrored
  wire [`ICM_POS_W-1:0] wr_col = pix_col - eff_cs;
  wire [`ICM_POS_W-1:0] rd_col_fwd = rd_idx;
  wire [`ICM_POS_W-1:0] rd_col_rev = rd_len - 11'h001 - rd_idx;
  wire [`ICM_POS_W-1:0] rd_col = rd_mirror ? rd_col_rev : rd_col_fwd;
  wire rd_en = (state == ST_READ);
  wire rd_end = rd_en & (rd_idx == rd_len - 11'h001);

  wire [`ICM_POS_W:0] col_sum = {1'b0, column_start_sw} + {1'b0, width_sw};
  wire [`ICM_POS_W:0] row_sum = {1'b0, row_start_sw} + {1'b0, height_sw};
  // software must keep these within the sensor; shown, not enforced
  wire win_ok = (col_sum <= {1'b0, `ICM_SENSOR_W}) &&
    (row_sum <= {1'b0, `ICM_SENSOR_H});

  icm_pos_track u_pos (
    .clk(CLK),
    .reset_n(RESET_N),
    .valid(PIX_VALID),
    .sof(PIX_SOF),
    .eol(PIX_EOL),
    .col(pix_col),
    .row(pix_row)
  );

  icm_line_buf u_buf (
    .clk(CLK),
    .reset_n(RESET_N),
    .wr_en(keep),
    .wr_addr({wr_bank, wr_col}),
    .wr_data(PIX_DATA),
    .rd_en(rd_en),
    .rd_addr({rd_bank, rd_col}),
    .rd_data(buf_dout)
  );

  // register writes; any value of one-pixel step is taken as written
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      column_start_sw <= `ICM_RST_COL_START;
      row_start_sw <= `ICM_RST_ROW_START;
      width_sw <= `ICM_RST_WIDTH;
      height_sw <= `ICM_RST_HEIGHT;
      mirror_enable_sw <= `ICM_RST_MIRROR;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `ICM_OFS_COL_START: column_start_sw <= REG_WDATA[10:0];
        `ICM_OFS_ROW_START: row_start_sw <= REG_WDATA[10:0];
        `ICM_OFS_WIDTH: width_sw <= REG_WDATA[10:0];
        `ICM_OFS_HEIGHT: height_sw <= REG_WDATA[10:0];
        `ICM_OFS_CTRL: begin
          mirror_enable_sw <= REG_WDATA[`ICM_CTRL_MIRROR];
        end
        default: begin
        end
      endcase
    end
  end

  // settings move into force at frame start only, so a position change
  // during capture never splits a frame
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      column_start <= `ICM_RST_COL_START;
      row_start <= `ICM_RST_ROW_START;
      width <= `ICM_RST_WIDTH;
      height <= `ICM_RST_HEIGHT;
      mirror_enable <= `ICM_RST_MIRROR;
    end else if (frame_start) begin
      column_start <= column_start_sw;
      row_start <= row_start_sw;
      width <= width_sw;
      height <= height_sw;
      mirror_enable <= mirror_enable_sw;
    end
  end

  always @* begin
    next_rdata = 32'h0000_0000;
    case (REG_ADDR)
      `ICM_OFS_COL_START: next_rdata[10:0] = column_start_sw;
      `ICM_OFS_ROW_START: next_rdata[10:0] = row_start_sw;
      `ICM_OFS_WIDTH: next_rdata[10:0] = width_sw;
      `ICM_OFS_HEIGHT: next_rdata[10:0] = height_sw;
      `ICM_OFS_CTRL: next_rdata[`ICM_CTRL_MIRROR] = mirror_enable_sw;
      `ICM_OFS_STATUS: begin
        next_rdata[`ICM_STAT_BUSY] = frame_busy;
        next_rdata[`ICM_STAT_WIN_OK] = win_ok;
        next_rdata[`ICM_STAT_FCNT_MSB:`ICM_STAT_FCNT_LSB] = frame_count;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data stands for one cycle only, zero otherwise
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end else begin
      REG_RDATA <= 32'h0000_0000;
    end
  end

  // a cropped line is played out from its bank once its input line ends;
  // the other bank takes the next line meanwhile
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= ST_IDLE;
      wr_bank <= 1'b0;
      rd_bank <= 1'b0;
      rd_len <= 11'h000;
      rd_idx <= 11'h000;
      rd_mirror <= 1'b0;
      rd_first <= 1'b0;
      rd_last <= 1'b0;
    end else if (line_done) begin
      state <= ST_READ;
      wr_bank <= ~wr_bank;
      rd_bank <= wr_bank;
      rd_len <= eff_w;
      rd_idx <= 11'h000;
      rd_mirror <= eff_mirror;
      rd_first <= (pix_row == eff_rs);
      rd_last <= is_last_row;
    end else begin
      case (state)
        ST_IDLE: begin
          rd_idx <= 11'h000;
        end
        ST_READ: begin
          if (rd_end) begin
            state <= ST_IDLE;
          end else begin
            rd_idx <= rd_idx + 11'h001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // tags ride alongside the one-cycle memory read
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s1_valid <= 1'b0;
      s1_sof <= 1'b0;
      s1_eol <= 1'b0;
      s1_eof <= 1'b0;
    end else begin
      s1_valid <= rd_en;
      s1_sof <= rd_en & rd_first & (rd_idx == 11'h000);
      s1_eol <= rd_end;
      s1_eof <= rd_end & rd_last;
    end
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OUT_VALID <= 1'b0;
      OUT_DATA <= {`ICM_PIX_W{1'b0}};
      OUT_SOF <= 1'b0;
      OUT_EOL <= 1'b0;
      OUT_EOF <= 1'b0;
    end else begin
      OUT_VALID <= s1_valid;
      OUT_DATA <= s1_valid ? buf_dout : {`ICM_PIX_W{1'b0}};
      OUT_SOF <= s1_sof;
      OUT_EOL <= s1_eol;
      OUT_EOF <= s1_eof;
    end
  end

  // busy from first input pixel to last output pixel of a frame
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      frame_busy <= 1'b0;
      frame_count <= 16'h0000;
    end else begin
      if (frame_start) begin
        frame_busy <= 1'b1;
      end else if (OUT_EOF) begin
        frame_busy <= 1'b0;
      end
      if (OUT_EOF) begin
        frame_count <= frame_count + 16'h0001;
      end
    end
  end
endmodule

// ==== tb/icm_crop_mirror_asserts.sv ====
// port-level checker for the crop and mirror stage
// assumes one clock domain and the active-low asynchronous reset
`timescale 1ns/1ps
module icm_crop_mirror_asserts (
  input wire CLK,
  input wire RESET_N,
  input wire [7:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  input wire [31:0] REG_RDATA,
  input wire OUT_VALID,
  input wire [11:0] OUT_DATA,
  input wire OUT_SOF,
  input wire OUT_EOL,
  input wire OUT_EOF
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data not zero outside read slot");
  a_unmapped_zero: assert property (REG_RD && REG_ADDR > 8'h14 |=>
    REG_RDATA == 32'h0) else $error("unmapped read not zero");
  a_col_readback: assert property ((REG_WR && REG_ADDR == 8'h00) ##1
    (REG_RD && REG_ADDR == 8'h00) |=> REG_RDATA ==
    {21'h0, $past(REG_WDATA[10:0], 2)}) else $error("column start lost");
  a_mirror_readback: assert property ((REG_WR && REG_ADDR == 8'h10) ##1
    (REG_RD && REG_ADDR == 8'h10) |=> REG_RDATA ==
    {31'h0, $past(REG_WDATA[0], 2)}) else $error("mirror bit lost");
  a_idle_data: assert property (!OUT_VALID |-> OUT_DATA == 12'h0)
    else $error("pixel data without valid");
  a_sof_start: assert property (OUT_SOF |->
    OUT_VALID && !$past(OUT_VALID))
    else $error("frame start not on a fresh line");
  a_eof_eol: assert property (OUT_EOF |-> OUT_EOL && OUT_VALID)
    else $error("frame end off a line end");
  a_line_burst: assert property (OUT_VALID && !OUT_EOL |=> OUT_VALID)
    else $error("gap inside an output line");
  c_sof: cover property (OUT_SOF);
  c_eof: cover property (OUT_EOF);
  c_readback: cover property (REG_WR ##1 REG_RD);
endmodule
bind icm_crop_mirror icm_crop_mirror_asserts chk_u (.CLK(CLK),
  .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .OUT_SOF(OUT_SOF),
  .OUT_EOL(OUT_EOL), .OUT_EOF(OUT_EOF));

// ==== tb/icm_host_sink.sv ====
// host-side sink: records every output pixel with its frame flags
// assumes no backpressure, so every valid cycle is taken
`timescale 1ns/1ps
module icm_host_sink (
  input wire clk,
  input wire reset_n,
  input wire valid,
  input wire [11:0] data,
  input wire sof,
  input wire eol,
  input wire eof
);
  logic [14:0] pix_q[$];
  int eof_count;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eof_count <= 0;
    end else if (valid) begin
      pix_q.push_back({sof, eol, eof, data});
      if (eof) begin
        eof_count <= eof_count + 1;
      end
    end
  end
endmodule

// ==== tb/icm_crop_mirror_test.sv ====
// self-checking bench for the crop and mirror stage
// assumes short 8x4 test frames; the window always fits inside them
`timescale 1ns/1ps
`include "icm_regs.vh"
module icm_crop_mirror_test;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, pv = 0, ps = 0, pe = 0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [11:0] pd = 12'h0, od;
  logic ov, os, oe, of;
  int n_mismatch = 0, n_tests = 0, n_frames = 0;
  always #2.5 clk = ~clk;
  icm_crop_mirror dut_u (.CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .PIX_VALID(pv), .PIX_DATA(pd), .PIX_SOF(ps), .PIX_EOL(pe),
    .OUT_VALID(ov), .OUT_DATA(od), .OUT_SOF(os), .OUT_EOL(oe), .OUT_EOF(of));
  icm_host_sink host_u (.clk(clk), .reset_n(rst_n), .valid(ov), .data(od),
    .sof(os), .eol(oe), .eof(of));
  task compare(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task reg_rd(input [7:0] a, output [31:0] v);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  // write then read straight back, no gap between the strobes
  task wr_rd(input [7:0] a, input [31:0] d);
    logic [31:0] v;
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    reg_rd(a, v);
    compare("readback", v, d);
  endtask
  // bench keeps start plus size within the sensor, sizes only when idle
  task set_win(input [10:0] cs, w, rs, h, input m);
    wr_rd(`ICM_OFS_COL_START, {21'h0, cs});
    wr_rd(`ICM_OFS_WIDTH, {21'h0, w});
    wr_rd(`ICM_OFS_ROW_START, {21'h0, rs});
    wr_rd(`ICM_OFS_HEIGHT, {21'h0, h});
    wr_rd(`ICM_OFS_CTRL, {31'h0, m});
  endtask
  task send_frame;
    int i;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 8; c++) begin
        pv <= 1;
        pd <= 12'(r * 16 + c);
        ps <= (r == 0 && c == 0);
        pe <= (c == 7);
        @(posedge clk);
      end
    end
    pv <= 0;
    ps <= 0;
    pe <= 0;
    pd <= 12'h0;
    n_frames++;
    for (i = 0; i < 100 && host_u.eof_count != n_frames; i++) @(posedge clk);
    if (i == 100) begin
      n_mismatch++;
      $display("BAD frame end expected %0d seen %0d", n_frames,
        host_u.eof_count);
      report_and_stop;
    end
  endtask
  task expect_frame(input int cs, w, rs, h, input bit m);
    int k, c;
    logic [14:0] e;
    k = 0;
    compare("pixel count", 32'(host_u.pix_q.size()), 32'(w * h));
    for (int r = rs; r < rs + h; r++) begin
      for (int i = 0; i < w; i++) begin
        c = m ? cs + w - 1 - i : cs + i;
        e = {r == rs && i == 0, i == w - 1, r == rs + h - 1 && i == w - 1,
          12'(r * 16 + c)};
        compare("pixel", 32'(host_u.pix_q[k]), 32'(e));
        k++;
      end
    end
    host_u.pix_q.delete();
  endtask
  task t_reset;
    logic [31:0] v;
    logic [31:0] exp [6];
    exp = '{32'h0, 32'h0, {21'h0, `ICM_SENSOR_W}, {21'h0, `ICM_SENSOR_H},
      32'h0, 32'h2};
    for (int i = 0; i < 6; i++) begin
      reg_rd(8'(i * 4), v);
      compare("reset value", v, exp[i]);
    end
    reg_rd(8'h20, v);
    compare("unmapped read", v, 32'h0);
  endtask
  task t_mid_frame;
    set_win(1, 2, 0, 2, 0);
    fork
      send_frame;
      begin
        logic [31:0] v;
        repeat (10) @(posedge clk);
        wr_rd(`ICM_OFS_COL_START, 32'h4);
        wr_rd(`ICM_OFS_ROW_START, 32'h1);
        wr_rd(`ICM_OFS_CTRL, 32'h1);
        // two frames done, third still arriving, window within sensor
        reg_rd(`ICM_OFS_STATUS, v);
        compare("status in frame", v, 32'h0002_0003);
      end
    join
    expect_frame(1, 2, 0, 2, 0);
    send_frame;
    expect_frame(4, 2, 1, 2, 1);
  endtask
  initial begin
    logic [31:0] v;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_reset;
    set_win(5, 3, 1, 2, 0);
    send_frame;
    expect_frame(5, 3, 1, 2, 0);
    set_win(0, 4, 0, 3, 1);
    send_frame;
    expect_frame(0, 4, 0, 3, 1);
    t_mid_frame;
    // four frames out, idle, window still within sensor
    reg_rd(`ICM_OFS_STATUS, v);
    compare("status at end", v, 32'h0004_0002);
    report_and_stop;
  end
endmodule
